// *** rtc_host_pkg.sv ***
/*
 * constants, state encodings and helpers for the hidden clock access host:
 * software register map, pin timing in clock cycles, the unlock pattern.
 * assumes a 20 MHz system clock and an sram-style device on the far side.
 */
package rtc_host_pkg;

   // pins and software port
   localparam int SRAM_AW = 19;
   localparam int BUS_AW  = 8;
   localparam int BUS_DW  = 32;

   // software registers (byte addresses)
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_SCRATCH   = 8'h04;
   localparam logic [7:0] REG_STATUS    = 8'h08;
   localparam logic [7:0] REG_DATA_BASE = 8'h20;
   localparam logic [7:0] REG_DATA_LAST = 8'h3C;

   // field positions
   localparam int CTRL_GO_BIT      = 0;
   localparam int CTRL_DIR_BIT     = 1;
   localparam int CTRL_ABORT_BIT   = 2;
   localparam int STAT_BUSY_BIT    = 0;
   localparam int STAT_DONE_BIT    = 1;
   localparam int STAT_ABORTED_BIT = 2;

   // values after reset
   localparam logic [SRAM_AW-1:0] SCRATCH_RESET = 19'h0_0000;
   localparam logic               DIR_RESET     = 1'b0;

   // stream geometry
   localparam int         PATTERN_BITS = 64;
   localparam int         CLOCK_BYTES  = 8;
   localparam logic [5:0] LAST_BIT     = 6'h3F;

   // comparison constant; must equal the one held by the device
   localparam logic [63:0] UNLOCK_PATTERN = 64'h5CA3_3AC5_5CA3_3AC5;

   // pin timing
   localparam int CLK_NS      = 50;
   localparam int STROBE_NS   = 85;
   localparam int RECOV_NS    = 20;
   localparam int ABORT_NS    = 85;
   localparam int SYNC_STAGES = 2;
   localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int RECOV_CYC   = (RECOV_NS + CLK_NS - 1) / CLK_NS;
   localparam int ABORT_CYC   = (ABORT_NS + CLK_NS - 1) / CLK_NS;
   // strobe also covers the input synchroniser so read data is sampled settled
   localparam logic [2:0] STROBE_LEN = 3'(STROBE_CYC + SYNC_STAGES + 1);
   localparam logic [2:0] RECOV_LEN  = 3'(RECOV_CYC);
   localparam logic [1:0] ABORT_LEN  = 2'(ABORT_CYC);

   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0001,
      ST_SETUP  = 4'b0010,
      ST_STROBE = 4'b0100,
      ST_RECOV  = 4'b1000
   } cyc_state_type;

   typedef enum logic [2:0] {
      SG_OPEN   = 3'b001,
      SG_UNLOCK = 3'b010,
      SG_XFER   = 3'b100
   } stage_type;

   function automatic logic is_data_reg(input logic [BUS_AW-1:0] a);
      return (a >= REG_DATA_BASE) && (a <= REG_DATA_LAST) && (a[1:0] == 2'b00);
   endfunction : is_data_reg

   function automatic logic [2:0] data_index(input logic [BUS_AW-1:0] a);
      return a[4:2];
   endfunction : data_index

endpackage : rtc_host_pkg

// *** clock_image_mem.sv ***
/*
 * eight-byte image of the clock registers: byte port for software,
 * bit port for the serial engine, registered read.
 * assumes the caller never writes the same byte through both ports at once.
 */
`timescale 1ns/1ps
module clock_image_mem (
   input  wire logic       clk_sys_in,
   input  wire logic       byte_we_in,
   input  wire logic [2:0] byte_idx_in,
   input  wire logic [7:0] byte_data_in,
   input  wire logic       bit_we_in,
   input  wire logic [5:0] bit_idx_in,
   input  wire logic       bit_data_in,
   input  wire logic [2:0] rd_idx_in,
   output logic      [7:0] rd_data_out
);
   logic [7:0] mem_q [0:7];

   always_ff @(posedge clk_sys_in) begin
      if (byte_we_in) begin
         mem_q[byte_idx_in] <= byte_data_in;
      end
      if (bit_we_in) begin
         mem_q[bit_idx_in[5:3]][bit_idx_in[2:0]] <= bit_data_in;
      end
      rd_data_out <= mem_q[rd_idx_in];
   end
endmodule : clock_image_mem

// *** rtc_unlock_host.sv ***
/*
 * host for the hidden clock behind a battery-backed sram: an opening read,
 * 64 unlock writes, then 64 serial clock bits in or out on data line zero.
 * assumes the device pins are board-level; data line zero is synchronised.
 */
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
// How it works
// R1 - unlock needs 64 consecutive writes whose data line zero bits match pattern
// R2 - before unlock the device treats every cycle as plain memory
// R3 - after unlock the next 64 cycles reach the clock, ram disabled
// R4 - each attempt opens with a chip-select and output-drive read
// R5 - unlock writes also hit ram, so all use one scratch address
// R6 - device advances its pointer on each matching unlock bit
// R7 - device ignores later writes after a mismatch until restarted
// R8 - any read during recognition restarts the device's pointer
// R9 - transfer reads return one bit, transfer writes give one bit, on line zero
// R10 - cycles to other memory never disturb the sequences
// R11 - pattern goes out least significant bit first
// R12 - clock data is eight bytes, bit 0 of byte 0 up to bit 7 of byte 7
// R13 - clock bytes are only moved as whole bytes
// R14 - clock fields are bcd with documented ranges
// R15 - hours bit 7 high picks 12-hour, low picks 24-hour
// R16 - hours bit 5 is pm flag or second tens-of-hours bit
// R17 - day bit 4 set masks abort pin; clear lets low abort transfer
// R18 - day bit 5 written zero starts the timebase
// R19 - unused clock bits read zero and accept any write
// R20 - both ends use the same 64-bit comparison constant
// R21 - after 64 transfer bits or abort a fresh unlock is needed
// R22 - running device advances bcd calendar with carries and leap years; the device model holds its timebase still instead
module rtc_unlock_host
   import rtc_host_pkg::*;
(
   input  wire logic                              clk_sys_in,
   input  wire logic                              sys_rst_in,
   input  wire logic [rtc_host_pkg::BUS_AW-1:0]   bus_addr_in,
   input  wire logic [rtc_host_pkg::BUS_DW-1:0]   bus_wdata_in,
   input  wire logic                              bus_write_in,
   input  wire logic                              bus_read_in,
   output logic      [rtc_host_pkg::BUS_DW-1:0]   bus_rdata_out,
   output logic      [rtc_host_pkg::SRAM_AW-1:0]  sram_addr_out,
   output logic                                   chip_sel_n_out,
   output logic                                   out_drive_n_out,
   output logic                                   write_strobe_n_out,
   input  wire logic                              data_line_zero_in,
   output logic                                   data_line_zero_out,
   output logic                                   data_line_zero_oe_n_out,
   output logic                                   abort_n_out
);
   import rtc_host_pkg::*;

   cyc_state_type      state_q, state_d;
   stage_type          stage_q, stage_d;
   logic [2:0]         cnt_q, cnt_d;
   logic [5:0]         bit_q, bit_d;
   logic               dir_q, dir_d;
   logic [SRAM_AW-1:0] scratch_q, scratch_d;
   logic               done_q, done_d;
   logic               aborted_q, aborted_d;
   logic [1:0]         abort_cnt_q, abort_cnt_d;
   logic               ce_n_q, ce_n_d;
   logic               oe_n_q, oe_n_d;
   logic               we_n_q, we_n_d;
   logic               dq_q, dq_d;
   logic               dq_oe_n_q, dq_oe_n_d;
   logic               abort_n_q, abort_n_d;
   logic [BUS_DW-1:0]  rdata_q, rdata_d;
   logic               rsel_mem_q, rsel_mem_d;
   logic               sync1_q, sync2_q;
   logic               bit_we;
   logic               byte_we;
   logic [2:0]         rd_idx;
   logic [7:0]         img_byte;
   logic               go_cmd, abort_cmd, wr_next, sample_now, fin_pulse;

   // data line zero comes from another chip: two flops before anything reads it
   always_ff @(posedge clk_sys_in) begin
      sync1_q <= data_line_zero_in;
      sync2_q <= sync1_q;
   end

   assign go_cmd    = bus_write_in && bus_addr_in == REG_CTRL && bus_wdata_in[CTRL_GO_BIT];
   assign abort_cmd = bus_write_in && bus_addr_in == REG_CTRL && bus_wdata_in[CTRL_ABORT_BIT];
   assign byte_we   = bus_write_in && is_data_reg(bus_addr_in) && state_q == ST_IDLE;
   // the engine owns the read port while busy; software sees its byte then
   assign rd_idx    = (state_q != ST_IDLE) ? bit_q[5:3] : data_index(bus_addr_in);
   assign sample_now = state_q == ST_STROBE && cnt_q == 3'd0;
   assign bit_we    = sample_now && stage_q == SG_XFER && !dir_q;        // [R9]

   clock_image_mem u_img (
      .clk_sys_in   (clk_sys_in),
      .byte_we_in   (byte_we),
      .byte_idx_in  (data_index(bus_addr_in)),
      .byte_data_in (bus_wdata_in[7:0]),
      .bit_we_in    (bit_we),
      .bit_idx_in   (bit_q),
      .bit_data_in  (sync2_q),
      .rd_idx_in    (rd_idx),
      .rd_data_out  (img_byte)
   );

   // sequencer: every operation is a full open/unlock/transfer unless an abort cuts it short
   always_comb begin
      state_d     = state_q;
      stage_d     = stage_q;
      cnt_d       = cnt_q;
      bit_d       = bit_q;
      dir_d       = dir_q;
      abort_cnt_d = (abort_cnt_q != 2'd0) ? abort_cnt_q - 2'd1 : 2'd0;
      fin_pulse   = 1'b0;
      unique case (state_q)
         ST_IDLE: begin
            if (go_cmd && !abort_cmd) begin
               stage_d = SG_OPEN;                                     // [R4]
               bit_d   = 6'd0;
               dir_d   = bus_wdata_in[CTRL_DIR_BIT];
               state_d = ST_SETUP;
            end
         end
         ST_SETUP: begin
            state_d = ST_STROBE;
            cnt_d   = STROBE_LEN - 3'd1;
         end
         ST_STROBE: begin
            if (cnt_q == 3'd0) begin
               state_d = ST_RECOV;
               cnt_d   = RECOV_LEN - 3'd1;
            end else begin
               cnt_d = cnt_q - 3'd1;
            end
         end
         ST_RECOV: begin
            if (cnt_q != 3'd0) begin
               cnt_d = cnt_q - 3'd1;
            end else begin
               state_d = ST_SETUP;
               unique case (stage_q)
                  SG_OPEN: begin
                     stage_d = SG_UNLOCK;
                     bit_d   = 6'd0;
                  end
                  SG_UNLOCK: begin
                     // all 64 bits go out; a device mismatch only shows later
                     if (bit_q == LAST_BIT) begin                     // [R1]
                        stage_d = SG_XFER;                            // [R3]
                        bit_d   = 6'd0;
                     end else begin
                        bit_d = bit_q + 6'd1;
                     end
                  end
                  SG_XFER: begin
                     if (bit_q == LAST_BIT) begin                     // [R12] [R13]
                        state_d   = ST_IDLE;                          // [R21]
                        fin_pulse = 1'b1;
                     end else begin
                        bit_d = bit_q + 6'd1;
                     end
                  end
                  default: stage_d = SG_OPEN;
               endcase
            end
         end
         default: state_d = ST_IDLE;
      endcase
      // abort cuts even a strobe in flight; chip select rises with the pulse
      if (abort_cmd) begin
         state_d     = ST_IDLE;                                       // [R17] [R21]
         abort_cnt_d = ABORT_LEN;
      end
   end

   // pin drive; strobe, enable and abort outputs are registered copies of next-state decode, data line zero follows the current state
   always_comb begin
      wr_next   = (stage_d == SG_UNLOCK) || (stage_d == SG_XFER && dir_d);
      ce_n_d    = state_d != ST_STROBE;
      oe_n_d    = !(state_d == ST_STROBE && !wr_next);                // [R4] [R9]
      we_n_d    = !(state_d == ST_STROBE && wr_next);
      dq_oe_n_d = !(wr_next && (state_d == ST_STROBE || state_d == ST_RECOV));
      dq_d      = dq_q;
      if (state_q == ST_STROBE) begin
         dq_d = (stage_q == SG_UNLOCK) ? UNLOCK_PATTERN[bit_q]        // [R11] [R20]
                                       : img_byte[bit_q[2:0]];       // [R12]
      end
      abort_n_d = abort_cnt_d == 2'd0;
   end

   // software registers
   always_comb begin
      scratch_d  = scratch_q;
      done_d     = done_q;
      aborted_d  = aborted_q;
      rdata_d    = '0;
      rsel_mem_d = 1'b0;
      if (bus_write_in && bus_addr_in == REG_SCRATCH) begin
         scratch_d = bus_wdata_in[SRAM_AW-1:0];                       // [R5]
      end
      if (bus_write_in && bus_addr_in == REG_STATUS) begin
         done_d    = done_q & ~bus_wdata_in[STAT_DONE_BIT];
         aborted_d = aborted_q & ~bus_wdata_in[STAT_ABORTED_BIT];
      end
      // set after clear so a same-cycle event is never lost
      if (fin_pulse) begin
         done_d = 1'b1;
      end
      if (abort_cmd && state_q != ST_IDLE) begin
         aborted_d = 1'b1;
      end
      if (bus_read_in) begin
         if (bus_addr_in == REG_CTRL) begin
            rdata_d[CTRL_DIR_BIT] = dir_q;
         end else if (bus_addr_in == REG_SCRATCH) begin
            rdata_d[SRAM_AW-1:0] = scratch_q;
         end else if (bus_addr_in == REG_STATUS) begin
            rdata_d[STAT_BUSY_BIT]    = state_q != ST_IDLE;
            rdata_d[STAT_DONE_BIT]    = done_q;
            rdata_d[STAT_ABORTED_BIT] = aborted_q;
         end else if (is_data_reg(bus_addr_in)) begin
            rsel_mem_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         state_q     <= ST_IDLE;
         stage_q     <= SG_OPEN;
         cnt_q       <= 3'd0;
         bit_q       <= 6'd0;
         dir_q       <= DIR_RESET;
         scratch_q   <= SCRATCH_RESET;
         done_q      <= 1'b0;
         aborted_q   <= 1'b0;
         abort_cnt_q <= 2'd0;
         ce_n_q      <= 1'b1;
         oe_n_q      <= 1'b1;
         we_n_q      <= 1'b1;
         dq_q        <= 1'b0;
         dq_oe_n_q   <= 1'b1;
         abort_n_q   <= 1'b1;
         rdata_q     <= '0;
         rsel_mem_q  <= 1'b0;
      end else begin
         state_q     <= state_d;
         stage_q     <= stage_d;
         cnt_q       <= cnt_d;
         bit_q       <= bit_d;
         dir_q       <= dir_d;
         scratch_q   <= scratch_d;
         done_q      <= done_d;
         aborted_q   <= aborted_d;
         abort_cnt_q <= abort_cnt_d;
         ce_n_q      <= ce_n_d;
         oe_n_q      <= oe_n_d;
         we_n_q      <= we_n_d;
         dq_q        <= dq_d;
         dq_oe_n_q   <= dq_oe_n_d;
         abort_n_q   <= abort_n_d;
         rdata_q     <= rdata_d;
         rsel_mem_q  <= rsel_mem_d;
      end
   end

   assign sram_addr_out           = scratch_q;                        // [R5]
   assign chip_sel_n_out          = ce_n_q;
   assign out_drive_n_out         = oe_n_q;
   assign write_strobe_n_out      = we_n_q;
   assign data_line_zero_out      = dq_q;
   assign data_line_zero_oe_n_out = dq_oe_n_q;
   assign abort_n_out             = abort_n_q;
   // byte image already comes out of a register; only the select is muxed
   assign bus_rdata_out = rsel_mem_q ? {24'h00_0000, img_byte} : rdata_q;

   // helper: counts unlock write strobes of the current operation
   logic [6:0] unlock_wr_q;
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in || (state_q == ST_IDLE)) begin
         unlock_wr_q <= 7'd0;
      end else if (stage_q == SG_UNLOCK && $fell(we_n_q)) begin
         unlock_wr_q <= unlock_wr_q + 7'd1;
      end
   end

   // helper: counts transfer strobes so a cut or stretched stream shows up
   logic [6:0] xfer_cyc_q;
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in || (state_q == ST_IDLE)) begin
         xfer_cyc_q <= 7'd0;
      end else if (stage_q == SG_XFER && $fell(ce_n_q)) begin
         xfer_cyc_q <= xfer_cyc_q + 7'd1;
      end
   end

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);

   unlock_count_a: assert property (                                  // [R1]
      (stage_q == SG_UNLOCK && stage_d == SG_XFER) |-> unlock_wr_q == 7'd64)
      else $error("transfer began without 64 unlock writes");
   open_read_a: assert property (                                     // [R4]
      (stage_q == SG_OPEN && state_q == ST_STROBE) |-> !oe_n_q && we_n_q)
      else $error("opening cycle is not a read");
   unlock_no_read_a: assert property (                                // [R1]
      stage_q == SG_UNLOCK |-> oe_n_q)
      else $error("read issued during unlock");
   pattern_bit_a: assert property (                                   // [R11] [R20]
      (stage_q == SG_UNLOCK && state_q == ST_RECOV && $rose(we_n_q)) |-> !dq_oe_n_q
         && dq_q == UNLOCK_PATTERN[bit_q])
      else $error("unlock bit does not match pattern");
   xfer_dir_a: assert property (                                      // [R9]
      (stage_q == SG_XFER && !dir_q && !ce_n_q) |-> dq_oe_n_q && we_n_q)
      else $error("clock read drives data line");
   strobe_width_a: assert property (                                  // [R3]
      disable iff (sys_rst_in || !abort_n_q)
      $fell(ce_n_q) |-> !ce_n_q [*5] ##1 ce_n_q)
      else $error("chip select width wrong");
   strobe_excl_a: assert property (
      !(oe_n_q == 1'b0 && we_n_q == 1'b0))
      else $error("read and write strobes together");
   abort_pulse_a: assert property (                                   // [R17]
      $fell(abort_n_q) |-> !abort_n_q [*2] ##1 abort_n_q)
      else $error("abort pulse width wrong");
   xfer_end_a: assert property (                                      // [R12] [R21]
      fin_pulse |-> bit_q == LAST_BIT && stage_q == SG_XFER ##1 done_q && ce_n_q)
      else $error("transfer ended early");
   scratch_hold_a: assert property (                                  // [R5]
      (state_q != ST_IDLE && !bus_write_in) |=> $stable(sram_addr_out))
      else $error("address moved during operation");

   xfer_count_a: assert property (                                    // [R3] [R12]
      fin_pulse |-> xfer_cyc_q == 7'd64)
      else $error("transfer did not take 64 cycles");

   idle_pins_a: assert property (                                     // [R21]
      state_q == ST_IDLE |-> ce_n_q && oe_n_q && we_n_q && dq_oe_n_q)
      else $error("device pins active while idle");

   abort_idle_a: assert property (                                    // [R17] [R21]
      abort_cmd |=> state_q == ST_IDLE && !abort_n_q)
      else $error("abort did not stop the engine");


   read_op_c:  cover property (fin_pulse && !dir_q);
   write_op_c: cover property (fin_pulse && dir_q);
   abort_op_c: cover property (abort_cmd && stage_q == SG_XFER);
   unlock_abort_c: cover property (abort_cmd && stage_q == SG_UNLOCK);
   done_clear_c: cover property (done_q ##1 !done_q);

endmodule : rtc_unlock_host

// *** rtc_dev_model.sv ***
/*
 * behavioural model of the sram with the hidden clock: unlock pattern
 * recognition, 64-bit serial transfer on data line zero, abort pin.
 * assumes host strobes are settled 1 ns after chip select falls.
 */
`timescale 1ns/1ps
module rtc_dev_model
   import rtc_host_pkg::*;
(
   input  wire logic [rtc_host_pkg::SRAM_AW-1:0] addr_in,
   input  wire logic                             chip_sel_n_in,
   input  wire logic                             out_drive_n_in,
   input  wire logic                             write_strobe_n_in,
   input  wire logic                             host_data_in,
   input  wire logic                             host_oe_n_in,
   input  wire logic                             abort_n_in,
   output logic                                  line_out
);
   import rtc_host_pkg::*;
   // must be the same constant the host sends
   localparam logic [63:0] DEV_PATTERN = UNLOCK_PATTERN;
   localparam logic [7:0] ZERO_MASK [8] = '{8'hFF, 8'h7F, 8'h7F, 8'hBF,
                                            8'h37, 8'h3F, 8'h1F, 8'hFF};
   // timebase held still so a read returns what was written, with unused bits cleared
   logic [7:0]         clk_regs [8];
   logic [6:0]         ptr;
   logic [6:0]         xfer_cnt;
   logic               armed;
   logic               miss;
   logic               unlocked;
   logic               is_rd;
   logic               is_wr;
   logic               last_lvl;
   logic               dev_drive;
   logic [SRAM_AW-1:0] last_addr;
   int                 ram_hits;
   int                 abort_cnt;

   initial begin
      ptr = '0;
      xfer_cnt = '0;
      armed = 1'b0;
      miss = 1'b0;
      unlocked = 1'b0;
      last_lvl = 1'b0;
      ram_hits = 0;
      abort_cnt = 0;
      for (int k = 0; k < 8; k++) begin
         clk_regs[k] = 8'h00;
      end
   end

   // one bit per read cycle, bit 0 of byte 0 first
   assign dev_drive = unlocked && !chip_sel_n_in && !out_drive_n_in;
   // a released line shows the inverse of its last level, not a held value
   assign line_out  = !host_oe_n_in ? host_data_in :
                      dev_drive ? clk_regs[xfer_cnt[5:3]][xfer_cnt[2:0]] : !last_lvl;

   always @(line_out) begin
      if (!host_oe_n_in || dev_drive) begin
         last_lvl = line_out;
      end
   end

   always @(negedge chip_sel_n_in) begin
      #1;
      is_rd = !out_drive_n_in;
      is_wr = !write_strobe_n_in;
   end

   // only this chip's select arrives here, so foreign cycles leave both sequences alone
   always @(posedge chip_sel_n_in) begin
      if (unlocked) begin
         // ram disabled; unused bits stored as zero
         if (is_wr) begin
            clk_regs[xfer_cnt[5:3]][xfer_cnt[2:0]] =
               line_out & ZERO_MASK[xfer_cnt[5:3]][xfer_cnt[2:0]];
         end
         xfer_cnt = xfer_cnt + 7'd1;
         if (xfer_cnt == 7'd64) begin
            unlocked = 1'b0;
         end
      end else begin
         ram_hits++;
         last_addr = addr_in;
         if (is_rd) begin
            armed = 1'b1;
            miss = 1'b0;
            ptr = '0;
         end else if (is_wr && armed && !miss) begin
            if (line_out == DEV_PATTERN[ptr[5:0]]) begin
               ptr = ptr + 7'd1;
               if (ptr == 7'd64) begin
                  unlocked = 1'b1;
                  armed = 1'b0;
                  xfer_cnt = '0;
               end
            end else begin
               miss = 1'b1;
            end
         end
      end
   end

   always @(negedge abort_n_in) begin
      abort_cnt++;
      if (!clk_regs[4][4]) begin
         unlocked = 1'b0;
         armed = 1'b0;
      end
   end
endmodule : rtc_dev_model

// *** tb_top.sv ***
/*
 * self-checking bench for the hidden clock host: register port tasks,
 * clock write, clock read, abort in mid-transfer.
 * assumes rtc_dev_model on the device pins.
 */
`timescale 1ns/1ps
module tb_top;
   import rtc_host_pkg::*;
   logic                clk_sys_in;
   logic                sys_rst_in;
   logic [BUS_AW-1:0]   bus_addr_in;
   logic [BUS_DW-1:0]   bus_wdata_in;
   logic [BUS_DW-1:0]   bus_rdata_out;
   logic                bus_write_in;
   logic                bus_read_in;
   logic [SRAM_AW-1:0]  sram_addr;
   logic                ce_n;
   logic                oe_n;
   logic                we_n;
   logic                line;
   logic                dl_out;
   logic                dl_oe_n;
   logic                abort_n;
   logic [31:0]         rv;
   int                  failures;
   int                  compares;
   int                  base;
   // unused bits set on purpose; expected image has them cleared
   // bcd values, 12 pm in 12-hour form, timebase running
   logic [7:0] wr_img [8]  = '{8'h99, 8'hD9, 8'hB7, 8'hF2, 8'hC3, 8'hF1, 8'hF2, 8'h99};
   logic [7:0] exp_img [8] = '{8'h99, 8'h59, 8'h37, 8'hB2, 8'h03, 8'h31, 8'h12, 8'h99};

   rtc_unlock_host i_rtc_unlock_host (
      .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .bus_addr_in(bus_addr_in),
      .bus_wdata_in(bus_wdata_in), .bus_write_in(bus_write_in), .bus_read_in(bus_read_in),
      .bus_rdata_out(bus_rdata_out), .sram_addr_out(sram_addr), .chip_sel_n_out(ce_n),
      .out_drive_n_out(oe_n), .write_strobe_n_out(we_n), .data_line_zero_in(line),
      .data_line_zero_out(dl_out), .data_line_zero_oe_n_out(dl_oe_n), .abort_n_out(abort_n));

   rtc_dev_model i_rtc_dev_model (
      .addr_in(sram_addr), .chip_sel_n_in(ce_n), .out_drive_n_in(oe_n),
      .write_strobe_n_in(we_n), .host_data_in(dl_out), .host_oe_n_in(dl_oe_n),
      .abort_n_in(abort_n), .line_out(line));

   initial begin
      clk_sys_in = 1'b0;
      forever #25 clk_sys_in = ~clk_sys_in;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic print_verdict;
      $display("comparisons %0d, mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : print_verdict

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      bus_addr_in  <= a;
      bus_wdata_in <= d;
      bus_write_in <= 1'b1;
      @(posedge clk_sys_in);
      bus_write_in <= 1'b0;
   endtask : bus_wr

   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys_in);
      bus_addr_in <= a;
      bus_read_in <= 1'b1;
      @(posedge clk_sys_in);
      bus_read_in <= 1'b0;
      #1;
      d = bus_rdata_out;
   endtask : bus_rd

   task automatic wait_idle;
      for (int n = 0; n < 1500; n++) begin
         bus_rd(REG_STATUS, rv);
         if (rv[STAT_BUSY_BIT] === 1'b0) begin
            return;
         end
      end
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, rv, 32'h0000_0000);
   endtask : wait_idle

   task automatic check_image;
      for (int k = 0; k < 8; k++) begin
         bus_rd(REG_DATA_BASE + 8'(4 * k), rv);
         check(rv, {24'h00_0000, exp_img[k]});
      end
   endtask : check_image

   task automatic test_reset;
      bus_rd(REG_CTRL, rv);
      check(rv, 32'h0000_0000);
      bus_rd(REG_SCRATCH, rv);
      check(rv, 32'h0000_0000);
      bus_rd(REG_STATUS, rv);
      check(rv, 32'h0000_0000);
      bus_rd(8'h10, rv);
      check(rv, 32'h0000_0000);
      $display("test reset done");
   endtask : test_reset

   task automatic test_write_clock;
      bus_wr(REG_SCRATCH, 32'h0001_2345);
      for (int k = 0; k < 8; k++) begin
         bus_wr(REG_DATA_BASE + 8'(4 * k), {24'h00_0000, wr_img[k]});
      end
      base = i_rtc_dev_model.ram_hits;
      bus_wr(REG_CTRL, 32'h0000_0003);
      // ignored while busy, so the device must still get the old byte
      bus_wr(REG_DATA_BASE, 32'h0000_0000);
      wait_idle();
      for (int k = 0; k < 8; k++) begin
         check(32'(i_rtc_dev_model.clk_regs[k]), {24'h00_0000, exp_img[k]});
      end
      check(i_rtc_dev_model.ram_hits - base, 65);
      check(32'(i_rtc_dev_model.last_addr), 32'h0001_2345);
      check(32'(i_rtc_dev_model.unlocked), 32'h0000_0000);
      bus_rd(REG_STATUS, rv);
      check(rv, 32'h0000_0002);
      bus_wr(REG_STATUS, 32'h0000_0002);
      bus_rd(REG_STATUS, rv);
      check(rv, 32'h0000_0000);
      $display("test write clock done");
   endtask : test_write_clock

   task automatic test_read_clock;
      for (int k = 0; k < 8; k++) begin
         bus_wr(REG_DATA_BASE + 8'(4 * k), 32'h0000_0000);
      end
      bus_wr(REG_CTRL, 32'h0000_0001);
      wait_idle();
      check_image();
      $display("test read clock done");
   endtask : test_read_clock

   task automatic test_abort;
      base = i_rtc_dev_model.abort_cnt;
      bus_wr(REG_CTRL, 32'h0000_0001);
      // lands inside the 64 transfer cycles
      repeat (600) @(posedge clk_sys_in);
      check(32'(i_rtc_dev_model.unlocked), 32'h0000_0001);
      bus_wr(REG_CTRL, 32'h0000_0004);
      repeat (4) @(posedge clk_sys_in);
      check(i_rtc_dev_model.abort_cnt - base, 1);
      check(32'(i_rtc_dev_model.unlocked), 32'h0000_0000);
      check(32'(i_rtc_dev_model.clk_regs[3]), 32'h0000_00B2);
      bus_rd(REG_STATUS, rv);
      // done from the read test is still sticky beside aborted
      check(rv, 32'h0000_0006);
      bus_wr(REG_STATUS, 32'h0000_0006);
      bus_wr(REG_CTRL, 32'h0000_0001);
      wait_idle();
      check_image();
      $display("test abort done");
   endtask : test_abort

   initial begin
      failures = 0;
      compares = 0;
      sys_rst_in = 1'b1;
      bus_addr_in = 8'h00;
      bus_wdata_in = 32'h0000_0000;
      bus_write_in = 1'b0;
      bus_read_in = 1'b0;
      repeat (4) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      test_reset();
      test_write_clock();
      test_read_clock();
      test_abort();
      print_verdict();
   end

   initial begin
      repeat (10000) @(posedge clk_sys_in);
      failures++;
      print_verdict();
   end
endmodule : tb_top
